// [hw/bchc_pkg.sv]
// Constants and types for the bridge configuration identity and command block
package bchc_pkg;

  // Register byte offsets
  localparam logic [7:0]  CFG_ID_OFFSET    = 8'h00;
  localparam logic [7:0]  CFG_CMD_OFFSET   = 8'h04;

  // Command field positions
  localparam int          CMD_IO_BIT       = 0;
  localparam int          CMD_MEM_BIT      = 1;
  localparam int          CMD_MASTER_BIT   = 2;
  localparam int          CMD_SPECIAL_BIT  = 3;

  // Identification word layout
  localparam int          ID_MAKER_LSB     = 0;
  localparam int          ID_PART_LSB      = 16;

  // Reset values
  localparam logic [2:0]  CMD_RESET        = 3'h0;
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

  typedef struct packed {
    logic [2:0]  cmd;
    logic        ack;
    logic [31:0] rdata;
  } bchc_cfg_s;

  typedef struct packed {
    logic io_claim;
    logic mem_claim;
    logic sec_claim;
    logic fwd_start;
  } bchc_gate_s;

endpackage

// [hw/bchc_gate.sv]
// Transaction claim and forwarding gates driven by the command enables
`timescale 1ns/10ps
module bchc_gate
  import bchc_pkg::*;
(
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset,
  // Command enables
  input  wire logic i_io_en,
  input  wire logic i_mem_en,
  input  wire logic i_master_en,
  // Decoded bus hits
  input  wire logic i_io_hit,
  input  wire logic i_mem_hit,
  input  wire logic i_sec_hit,
  input  wire logic i_fwd_req,
  // Gated results
  output logic      o_io_claim,
  output logic      o_mem_claim,
  output logic      o_sec_claim,
  output logic      o_fwd_start
);

  bchc_gate_s state_ff;
  bchc_gate_s nxt_state;

  always_comb begin
    nxt_state           = state_ff;
    nxt_state.io_claim  = i_io_hit && i_io_en;
    nxt_state.mem_claim = i_mem_hit && i_mem_en;
    // Secondary response and primary mastering share one enable
    nxt_state.sec_claim = i_sec_hit && i_master_en;
    nxt_state.fwd_start = i_fwd_req && i_master_en;
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_io_claim  = state_ff.io_claim;
  assign o_mem_claim = state_ff.mem_claim;
  assign o_sec_claim = state_ff.sec_claim;
  assign o_fwd_start = state_ff.fwd_start;

endmodule

// [hw/bchc_top.sv]
// Identification word, primary command register and the claim gates they steer
`timescale 1ns/10ps
module bchc_top
  import bchc_pkg::*;
#(
  // Arbitrary neutral identity values
  parameter logic [15:0] P_MAKER_ID = 16'h1A2B,
  parameter logic [15:0] P_PART_ID  = 16'h3C4D
)
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // Configuration access
  input  wire logic        i_cfg_valid,
  input  wire logic        i_cfg_write,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [31:0] i_cfg_wdata,
  input  wire logic [3:0]  i_cfg_byte_en,
  output logic             o_cfg_ack,
  output logic [31:0]      o_cfg_rdata,
  // Decoded bus hits
  input  wire logic        i_io_hit,
  input  wire logic        i_mem_hit,
  input  wire logic        i_sec_hit,
  input  wire logic        i_fwd_req,
  // Gated results
  output logic             o_io_claim,
  output logic             o_mem_claim,
  output logic             o_sec_claim,
  output logic             o_fwd_start,
  // Command state
  output logic             o_io_en,
  output logic             o_mem_en,
  output logic             o_master_en
);

  bchc_cfg_s state_ff;
  bchc_cfg_s nxt_state;

  // Word match ignoring the byte lane bits
  function automatic logic is_word(input logic [7:0] addr, input logic [7:0] off);
    is_word = (addr[7:2] == off[7:2]);
  endfunction

  logic id_hit;
  logic cmd_hit;
  assign id_hit  = is_word(i_cfg_addr, CFG_ID_OFFSET);
  assign cmd_hit = is_word(i_cfg_addr, CFG_CMD_OFFSET);

  always_comb begin
    nxt_state       = state_ff;
    nxt_state.ack   = i_cfg_valid;
    nxt_state.rdata = RDATA_RESET;
    if (i_cfg_valid && !i_cfg_write) begin
      if (id_hit) begin
        nxt_state.rdata[ID_MAKER_LSB +: 16] = P_MAKER_ID;
        nxt_state.rdata[ID_PART_LSB +: 16]  = P_PART_ID;
      end else if (cmd_hit) begin
        // Special cycle bit left at zero; status half not modelled here
        nxt_state.rdata[2:0] = state_ff.cmd;
      end
    end
    // Identity word has no storage, so writes there fall through
    if (i_cfg_valid && i_cfg_write && cmd_hit && i_cfg_byte_en[0]) begin
      nxt_state.cmd[CMD_IO_BIT]     = i_cfg_wdata[CMD_IO_BIT];
      nxt_state.cmd[CMD_MEM_BIT]    = i_cfg_wdata[CMD_MEM_BIT];
      nxt_state.cmd[CMD_MASTER_BIT] = i_cfg_wdata[CMD_MASTER_BIT];
      // Written special cycle bit is dropped: nothing here acts on it
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_ff.cmd   <= CMD_RESET;
      state_ff.ack   <= 1'b0;
      state_ff.rdata <= RDATA_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_cfg_ack   = state_ff.ack;
  assign o_cfg_rdata = state_ff.rdata;
  assign o_io_en     = state_ff.cmd[CMD_IO_BIT];
  assign o_mem_en    = state_ff.cmd[CMD_MEM_BIT];
  assign o_master_en = state_ff.cmd[CMD_MASTER_BIT];

  bchc_gate u_gate (
    .i_clock     (i_clock),
    .i_reset     (i_reset),
    .i_io_en     (state_ff.cmd[CMD_IO_BIT]),
    .i_mem_en    (state_ff.cmd[CMD_MEM_BIT]),
    .i_master_en (state_ff.cmd[CMD_MASTER_BIT]),
    .i_io_hit    (i_io_hit),
    .i_mem_hit   (i_mem_hit),
    .i_sec_hit   (i_sec_hit),
    .i_fwd_req   (i_fwd_req),
    .o_io_claim  (o_io_claim),
    .o_mem_claim (o_mem_claim),
    .o_sec_claim (o_sec_claim),
    .o_fwd_start (o_fwd_start)
  );

  // Checks
  logic id_read;
  logic cmd_read;
  logic cmd_write;
  logic id_write;
  assign id_read   = i_cfg_valid && !i_cfg_write && id_hit;
  assign cmd_read  = i_cfg_valid && !i_cfg_write && cmd_hit;
  assign cmd_write = i_cfg_valid && i_cfg_write && cmd_hit && i_cfg_byte_en[0];
  assign id_write  = i_cfg_valid && i_cfg_write && id_hit;

  AST_MAKER_ID: assert property (
    @(posedge i_clock) disable iff (i_reset)
    id_read |=> o_cfg_ack && (o_cfg_rdata[15:0] == P_MAKER_ID))
    else $error("maker code wrong on identity read");

  AST_PART_ID: assert property (
    @(posedge i_clock) disable iff (i_reset)
    id_read |=> o_cfg_ack && (o_cfg_rdata[31:16] == P_PART_ID))
    else $error("part code wrong on identity read");

  AST_ID_WRITE_IGNORED: assert property (
    @(posedge i_clock) disable iff (i_reset)
    id_write ##[1:4] id_read |=> (o_cfg_rdata == {P_PART_ID, P_MAKER_ID}))
    else $error("identity word changed after a write");

  AST_IO_GATE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    o_io_claim |-> $past(i_io_hit) && $past(o_io_en))
    else $error("I/O claimed without enable and hit");

  AST_MEM_GATE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_mem_hit && o_mem_en) |=> o_mem_claim)
    else $error("enabled memory hit not claimed");

  AST_MEM_OFF: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !o_mem_en |=> !o_mem_claim)
    else $error("memory claimed while disabled");

  AST_MASTER_OFF: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !o_master_en |=> !o_fwd_start && !o_sec_claim)
    else $error("master activity while master enable is 0");

  AST_MASTER_ON: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_master_en && i_fwd_req) |=> o_fwd_start)
    else $error("forward request not started while enabled");

  AST_CMD_WRITE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    cmd_write |=> ({o_master_en, o_mem_en, o_io_en} == $past(i_cfg_wdata[2:0])))
    else $error("command enables did not take written value");

  AST_SPECIAL_ZERO: assert property (
    @(posedge i_clock) disable iff (i_reset)
    cmd_read |=> o_cfg_ack && (o_cfg_rdata[CMD_SPECIAL_BIT] == 1'b0) && (o_cfg_rdata[31:3] == '0))
    else $error("special cycle or unused command bits read nonzero");

  AST_SPECIAL_NO_EFFECT: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (cmd_write && i_cfg_wdata[CMD_SPECIAL_BIT]) |=> ({o_master_en, o_mem_en, o_io_en} == $past(i_cfg_wdata[2:0])))
    else $error("special cycle write disturbed other enables");

  AST_ACK_ONE: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !i_cfg_valid |=> !o_cfg_ack)
    else $error("acknowledge without request");

  AST_ACK_EVERY: assert property (
    @(posedge i_clock) disable iff (i_reset)
    i_cfg_valid |=> o_cfg_ack)
    else $error("request not acknowledged in the next cycle");

  AST_RDATA_QUIET: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !(i_cfg_valid && !i_cfg_write) |=> (o_cfg_rdata == '0))
    else $error("read data nonzero outside a read answer");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_cfg_valid && !i_cfg_write && !id_hit && !cmd_hit) |=> o_cfg_ack && (o_cfg_rdata == '0))
    else $error("unmapped word read nonzero");

  AST_IO_ON: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_io_hit && o_io_en) |=> o_io_claim)
    else $error("enabled I/O hit not claimed");

  AST_IO_OFF: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !o_io_en |=> !o_io_claim)
    else $error("I/O claimed while disabled");

  AST_MEM_NO_HIT: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !i_mem_hit |=> !o_mem_claim)
    else $error("memory claimed without a hit");

  AST_SEC_ON: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (o_master_en && i_sec_hit) |=> o_sec_claim)
    else $error("secondary hit not claimed while master enabled");

  AST_FWD_NO_REQ: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !i_fwd_req |=> !o_fwd_start)
    else $error("forward started without a request");

  AST_CMD_HOLD: assert property (
    @(posedge i_clock) disable iff (i_reset)
    !cmd_write |=> $stable({o_master_en, o_mem_en, o_io_en}))
    else $error("command enables changed without a command write");

  AST_LANE_OFF: assert property (
    @(posedge i_clock) disable iff (i_reset)
    (i_cfg_valid && i_cfg_write && cmd_hit && !i_cfg_byte_en[0]) |=> $stable({o_master_en, o_mem_en, o_io_en}))
    else $error("command write with lane 0 off changed the enables");

  COV_IO_CLAIM: cover property (@(posedge i_clock) disable iff (i_reset) o_io_claim);
  COV_MEM_CLAIM: cover property (@(posedge i_clock) disable iff (i_reset) o_mem_claim);
  COV_FWD: cover property (@(posedge i_clock) disable iff (i_reset) cmd_write ##1 o_master_en ##[1:4] o_fwd_start);
  COV_ID_READ: cover property (@(posedge i_clock) disable iff (i_reset) id_read ##1 o_cfg_ack);

endmodule

// [verification/bchc_host.sv]
// Primary-side configuration host model
`timescale 1ns/10ps
module bchc_host (
  // Clock
  input  wire logic        i_clock,
  // Answer from the bridge
  input  wire logic        i_cfg_ack,
  input  wire logic [31:0] i_cfg_rdata,
  // Configuration request
  output logic             o_cfg_valid,
  output logic             o_cfg_write,
  output logic [7:0]       o_cfg_addr,
  output logic [31:0]      o_cfg_wdata,
  output logic [3:0]       o_cfg_byte_en
);
  initial begin
    o_cfg_valid   = 1'b0;
    o_cfg_write   = 1'b0;
    o_cfg_addr    = 8'h00;
    o_cfg_wdata   = 32'h0000_0000;
    o_cfg_byte_en = 4'h0;
  end

  // Enables are only ever set by these accesses
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                        output logic ack, output logic [31:0] rd);
    @(posedge i_clock);
    o_cfg_valid   <= 1'b1;
    o_cfg_write   <= wr;
    o_cfg_addr    <= a;
    o_cfg_wdata   <= d;
    o_cfg_byte_en <= be;
    @(posedge i_clock);
    // Released address, data and lane lines show stale inverted values, not the last ones
    o_cfg_valid   <= 1'b0;
    o_cfg_addr    <= ~a;
    o_cfg_wdata   <= ~d;
    o_cfg_byte_en <= ~be;
    @(negedge i_clock);
    ack = i_cfg_ack;
    rd  = i_cfg_rdata;
  endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the identity word, command register and claim gates
`timescale 1ns/10ps
module tb;
  import bchc_pkg::*;
  localparam logic [15:0] MAKER = 16'h5A01;  // Arbitrary identity value
  localparam logic [15:0] PART  = 16'h6B02;  // Arbitrary identity value
  logic        i_clock  = 1'b0;
  logic        i_reset  = 1'b1;
  logic [3:0]  hit      = 4'h0;
  logic        valid, write, ack, o_cfg_ack, o_io_en, o_mem_en, o_master_en;
  logic [3:0]  be, claim;
  logic [7:0]  addr;
  logic [31:0] wdata, rd, o_cfg_rdata;
  int          failures = 0;
  int          n_checks = 0;

  always #4 i_clock = ~i_clock;

  bchc_host host_u (.i_clock(i_clock), .i_cfg_ack(o_cfg_ack), .i_cfg_rdata(o_cfg_rdata),
    .o_cfg_valid(valid), .o_cfg_write(write), .o_cfg_addr(addr), .o_cfg_wdata(wdata), .o_cfg_byte_en(be));

  bchc_top #(.P_MAKER_ID(MAKER), .P_PART_ID(PART)) dut_u (.i_clock(i_clock), .i_reset(i_reset),
    .i_cfg_valid(valid), .i_cfg_write(write), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
    .i_cfg_byte_en(be), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .i_io_hit(hit[0]), .i_mem_hit(hit[1]), .i_sec_hit(hit[2]), .i_fwd_req(hit[3]),
    .o_io_claim(claim[0]), .o_mem_claim(claim[1]), .o_sec_claim(claim[2]), .o_fwd_start(claim[3]),
    .o_io_en(o_io_en), .o_mem_en(o_mem_en), .o_master_en(o_master_en));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host_u.access(1'b0, a, 32'h0000_0000, 4'hF, ack, rd);
    check("read_ack", {31'h0, ack}, 32'h0000_0001);
    check("rdata", rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    host_u.access(1'b1, a, d, b, ack, rd);
    check("write_ack", {31'h0, ack}, 32'h0000_0001);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under 300 cycles
  initial begin
    #20000;
    failures++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    check("en_reset", {29'h0, o_master_en, o_mem_en, o_io_en}, 32'h0);
    rd_chk(CFG_ID_OFFSET, {PART, MAKER});
    rd_chk(CFG_CMD_OFFSET, 32'h0000_0000);
    wr(CFG_ID_OFFSET, 32'hFFFF_FFFF, 4'hF);
    rd_chk(CFG_ID_OFFSET, {PART, MAKER});
    wr(CFG_CMD_OFFSET, 32'h0000_000F, 4'h0);
    rd_chk(CFG_CMD_OFFSET, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0000);
    @(posedge i_clock);
    hit <= 4'hF;
    @(negedge i_clock);
    @(negedge i_clock);
    check("claims_off", {28'h0, claim}, 32'h0);
    // Every command value, with the upper bits set and the special-cycle bit both clear and set
    for (int c = 0; c < 16; c++) begin
      wr(CFG_CMD_OFFSET, 32'hFFFF_FFF0 | c, 4'h1);
      @(negedge i_clock);
      check("claims", {28'h0, claim}, {28'h0, c[2], c[2], c[1], c[0]});
      check("enables", {29'h0, o_master_en, o_mem_en, o_io_en}, {29'h0, c[2:0]});
      rd_chk(CFG_CMD_OFFSET, {29'h0, c[2:0]});
    end
    @(posedge i_clock);
    hit <= 4'h0;
    @(negedge i_clock);
    @(negedge i_clock);
    check("claims_idle", {28'h0, claim}, 32'h0);
    // Reset in mid-run must drop every enable again
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    check("en_rereset", {29'h0, o_master_en, o_mem_en, o_io_en}, 32'h0);
    rd_chk(CFG_CMD_OFFSET, 32'h0000_0000);
    stop_test();
  end
endmodule
